/* File: src/jtap_brk_unit.sv */
// jtap_brk_unit: break point compare for program and data addresses
// assumes: addresses and event strobes come from the core on pclk
`timescale 1ns/1ns
`default_nettype none
module jtap_brk_unit
  import jtap_pkg::*;
(
  // configuration
  input wire jtap_bp_t bp [4],
  input wire logic flow_en,
  input wire logic step_en,
  // core activity
  input wire logic [15:0] pc_addr,
  input wire logic [15:0] data_addr,
  input wire logic insn_valid,
  input wire logic flow_change,
  input wire logic data_valid,
  // per source hit this cycle: bp0..3, flow, step
  output logic [5:0] hit
);

  // each break point compares under its mask; only 2 and 3 may match data
  for (genvar i = 0; i < 4; i++) begin : g_bp
    logic [15:0] cmp;
    logic is_data;
    assign is_data = (i >= 2) && bp[i].data;
    assign cmp = is_data ? data_addr : pc_addr;
    assign hit[i] = bp[i].en && (is_data ? data_valid : insn_valid) &&
                    (((cmp ^ bp[i].addr) & ~{2'b00, bp[i].mask}) == 16'h0000);
  end

  assign hit[4] = flow_en & flow_change;
  assign hit[5] = step_en & insn_valid;

endmodule : jtap_brk_unit
`default_nettype wire

/* File: src/jtap_pin_sync.sv */
// jtap_pin_sync: two-flop synchronisers for tck, tms, tdi plus tck edges
// assumes: pins are asynchronous to pclk; tck much slower than pclk
`timescale 1ns/1ns
`default_nettype none
module jtap_pin_sync
  import jtap_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  // synchronised view
  output jtap_pins_t pins
);

  logic [2:0] s1_r;    // first stage, read only by second stage
  logic [2:0] s2_r;    // second stage
  logic tck_d_r;       // delayed tck for edge finding

  // two flip-flops per pin, plus a third on tck for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      tck_d_r <= 1'b0;
    end else begin
      s1_r <= {tck, tms, tdi};
      s2_r <= s1_r;
      tck_d_r <= s2_r[2];
    end
  end

  // edges from the second stage only
  assign pins.tck_rise = s2_r[2] & ~tck_d_r;
  assign pins.tck_fall = ~s2_r[2] & tck_d_r;
  assign pins.tms = s2_r[1];
  assign pins.tdi = s2_r[0];

endmodule : jtap_pin_sync
`default_nettype wire

/* File: src/jtap_pkg.sv */
// jtap_pkg: constants and types for the test access port block
// assumes: included before every design file of the block
package jtap_pkg;

  // ****************************************************
  // apb register map
  // ****************************************************
  localparam logic [7:0] JTAP_CTRL_OFS = 8'h00;   // control: disable bit, fuses, locks
  localparam logic [7:0] JTAP_STAT_OFS = 8'h04;   // status: tap state, instruction, scan outputs
  localparam logic [7:0] JTAP_DCHN_OFS = 8'h08;   // cpu to debugger byte channel
  localparam logic [7:0] JTAP_BRKC_OFS = 8'h0C;   // break unit control
  localparam logic [7:0] JTAP_BP0_OFS = 8'h10;    // break point 0..3 at 0x10..0x1C
  localparam logic [7:0] JTAP_BRKS_OFS = 8'h20;   // break status (sticky hits)
  localparam logic [7:0] JTAP_PCDA_OFS = 8'h24;   // observed program and data addresses

  // ****************************************************
  // reset values and field positions
  // ****************************************************
  localparam logic [31:0] JTAP_CTRL_RST = 32'h0000_0006; // enable fuse, debug fuse set
  localparam int JTAP_CTRL_DIS = 0;   // test_port_disable_bit
  localparam int JTAP_CTRL_EN = 1;    // test_port_enable_fuse
  localparam int JTAP_CTRL_DBG = 2;   // debug_enable_fuse
  localparam int JTAP_CTRL_LB1 = 3;   // lock_bit_one
  localparam int JTAP_CTRL_LB2 = 4;   // lock_bit_two

  // ****************************************************
  // tap constants
  // ****************************************************
  localparam logic [3:0] JTAP_IR_CAPTURE = 4'h1;  // fixed captured ir value
  localparam logic [3:0] JTAP_IR_EXTEST = 4'h0;
  localparam logic [3:0] JTAP_IR_IDCODE = 4'h1;   // default instruction
  localparam logic [3:0] JTAP_IR_SAMPLE = 4'h2;
  localparam logic [3:0] JTAP_IR_RESET = 4'hC;    // reset data register
  localparam logic [3:0] JTAP_IR_BYPASS = 4'hF;
  localparam logic [31:0] JTAP_IDCODE_VAL = 32'h1234_5001; // arbitrary identity value
  localparam int JTAP_RESET_ONES = 5;             // tms-high periods to reset

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jtap_state_t;

  // synchronised pin levels and edge pulses
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
  } jtap_pins_t;

  // break point entry: kind and address
  typedef struct packed {
    logic en;       // break point active
    logic data;     // data memory rather than program memory
    logic [13:0] mask;
    logic [15:0] addr;
  } jtap_bp_t;

endpackage : jtap_pkg

/* File: src/jtap_top.sv */
// jtap_top: test access port controller, data registers, apb regs, break unit
// assumes: tck/tms/tdi asynchronous pins sampled on pclk (250 MHz);
//          apb master on pclk; core signals on pclk
//
// Overview of operation
// - sixteen state machine stepped by tms on tck rise
// - power-on reset starts in test-logic-reset
// - all shifts least significant bit first
// - shift-ir outputs captured value 0x01
// - last bit taken when leaving shift with tms
// - instruction updates only in update-ir or to idcode in test-logic-reset, selects register
// - shift-dr outputs captured parallel inputs
// - latched outputs update only in update-dr
// - exit and pause states do nothing
// - five tms-high periods reach test-logic-reset
// - no test reset pin
// - enable fuse clear: pins normal, tap reset
// - fuse set, disable clear: pullups, port enabled
// - debug needs both fuses, no lock bits
// - break on flow change and single step
// - two program, two combined break points
// - cpu writes results to channel location
// - bypass single stage, zero after capture
// - idcode is the default instruction
`timescale 1ns/1ns
`default_nettype none
module jtap_top
  import jtap_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic pins_pullup,
  // core side
  input wire logic [15:0] pc_addr,
  input wire logic [15:0] data_addr,
  input wire logic insn_valid,
  input wire logic flow_change,
  input wire logic data_valid,
  input wire logic chan_wr,
  input wire logic [7:0] chan_wdata,
  output logic chan_flag,
  output logic brk_req,
  output logic dbg_enable,
  output logic sys_reset_req
);

  // ****************************************************
  // pin synchroniser
  // ****************************************************
  jtap_pins_t pins;  // synchronised tck edges, tms, tdi

  jtap_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .pins(pins)
  );

  // ****************************************************
  // control register and enables
  // ****************************************************
  logic [31:0] ctrl_r;       // fuses, disable bit, locks
  logic port_en;             // test port enabled
  logic dbg_ok;              // debug allowed

  assign port_en = ctrl_r[JTAP_CTRL_EN] & ~ctrl_r[JTAP_CTRL_DIS];
  assign dbg_ok = port_en & ctrl_r[JTAP_CTRL_DBG] &
                  ~ctrl_r[JTAP_CTRL_LB1] & ~ctrl_r[JTAP_CTRL_LB2];

  // ****************************************************
  // tap state machine
  // ****************************************************
  jtap_state_t state_r;      // current tap state
  jtap_state_t state_nxt;    // next on tck rise

  // tms-driven transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TLR: state_nxt = pins.tms ? TLR : RTI;
      RTI: state_nxt = pins.tms ? SEL_DR : RTI;
      SEL_DR: state_nxt = pins.tms ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = pins.tms ? EX1_DR : SH_DR;
      SH_DR: state_nxt = pins.tms ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = pins.tms ? UPD_DR : PAU_DR;
      PAU_DR: state_nxt = pins.tms ? EX2_DR : PAU_DR;
      EX2_DR: state_nxt = pins.tms ? UPD_DR : SH_DR;
      UPD_DR: state_nxt = pins.tms ? SEL_DR : RTI;
      SEL_IR: state_nxt = pins.tms ? TLR : CAP_IR;
      CAP_IR: state_nxt = pins.tms ? EX1_IR : SH_IR;
      SH_IR: state_nxt = pins.tms ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = pins.tms ? UPD_IR : PAU_IR;
      PAU_IR: state_nxt = pins.tms ? EX2_IR : PAU_IR;
      EX2_IR: state_nxt = pins.tms ? UPD_IR : SH_IR;
      UPD_IR: state_nxt = pins.tms ? SEL_DR : RTI;
    endcase
  end

  // state register; only presetn or a disabled port (fuse clear or disable bit set) resets it, no test reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TLR;
    end else if (!port_en) begin
      state_r <= TLR;
    end else if (pins.tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************
  // instruction register
  // ****************************************************
  logic [3:0] ir_sh_r;       // instruction shift stage
  logic [3:0] ir_r;          // latched instruction

  // capture, shift lsb first, update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_sh_r <= 4'h0;
      ir_r <= JTAP_IR_IDCODE;
    end else if (state_r == TLR) begin
      ir_r <= JTAP_IR_IDCODE;
    end else if (pins.tck_rise) begin
      unique case (state_r)
        CAP_IR: ir_sh_r <= JTAP_IR_CAPTURE;
        SH_IR: ir_sh_r <= {pins.tdi, ir_sh_r[3:1]};
        UPD_IR: ir_r <= ir_sh_r;
        default: ;
      endcase
    end
  end

  // ****************************************************
  // data registers
  // ****************************************************
  logic [31:0] dr_sh_r;      // shared data shift stage
  logic [5:0] dr_len;        // length of selected register
  logic [31:0] dr_cap;       // parallel capture value
  logic [15:0] pins_sample;  // sampled core view for sample/extest
  logic rst_dr_r;            // reset data register output, unlatched
  logic [15:0] scan_out_r;   // latched scan outputs

  assign pins_sample = pc_addr;

  // selected register by instruction
  always_comb begin
    dr_len = 6'd1;
    dr_cap = 32'h0000_0000;                               // bypass captures zero
    unique case (ir_r)
      JTAP_IR_IDCODE: begin
        dr_len = 6'd32;
        dr_cap = JTAP_IDCODE_VAL;
      end
      JTAP_IR_EXTEST, JTAP_IR_SAMPLE: begin
        dr_len = 6'd16;
        dr_cap = {16'h0000, pins_sample};
      end
      JTAP_IR_RESET: begin
        dr_len = 6'd1;
        dr_cap = 32'h0000_0000;
      end
      default: ;
    endcase
  end

  // capture, shift lsb first into the top of the selected length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_sh_r <= 32'h0000_0000;
    end else if (pins.tck_rise) begin
      unique case (state_r)
        CAP_DR: dr_sh_r <= dr_cap;
        SH_DR: begin
          dr_sh_r <= dr_sh_r >> 1;
          dr_sh_r[dr_len[4:0] - 5'd1] <= pins.tdi;
        end
        default: ;
      endcase
    end
  end

  // latched parallel outputs change only in update-dr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_out_r <= 16'h0000;
      rst_dr_r <= 1'b0;
    end else if (state_r == TLR) begin
      rst_dr_r <= 1'b0;
    end else if (pins.tck_rise && state_r == UPD_DR && ir_r == JTAP_IR_EXTEST) begin
      scan_out_r <= dr_sh_r[15:0];
    end else if (pins.tck_rise && state_r == SH_DR && ir_r == JTAP_IR_RESET) begin
      rst_dr_r <= pins.tdi;                               // unlatched output
    end
  end

  // ****************************************************
  // tdo on falling tck, driven only in shift states
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!port_en) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (pins.tck_fall) begin
      tdo_oe <= (state_r == SH_IR) || (state_r == SH_DR);
      tdo <= (state_r == SH_IR) ? ir_sh_r[0] :
             (state_r == SH_DR) ? dr_sh_r[0] : 1'b0;
    end
  end

  // ****************************************************
  // break unit
  // ****************************************************
  jtap_bp_t bp_r [4];        // break point entries
  logic [1:0] brkc_r;        // flow, step enables
  logic [5:0] hit;           // per source hits
  logic [5:0] brks_r;        // sticky hits

  jtap_brk_unit u_brk (
    .bp(bp_r),
    .flow_en(brkc_r[0]),
    .step_en(brkc_r[1]),
    .pc_addr(pc_addr),
    .data_addr(data_addr),
    .insn_valid(insn_valid),
    .flow_change(flow_change),
    .data_valid(data_valid),
    .hit(hit)
  );

  // ****************************************************
  // apb slave: zero wait, error on unmapped address
  // ****************************************************
  logic wr_en;               // write in access phase
  logic rd_en;               // read in access phase
  logic hit_ofs;             // address is mapped
  logic [31:0] rd_mux;       // read value
  logic [7:0] chan_r;        // channel byte
  logic chan_clr;            // debugger reads the channel

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign chan_clr = rd_en && paddr == JTAP_DCHN_OFS;

  // read decode
  always_comb begin
    hit_ofs = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      JTAP_CTRL_OFS: rd_mux = ctrl_r;
      JTAP_STAT_OFS: rd_mux = {scan_out_r, 6'h00, dbg_ok, port_en, ir_r, state_r};
      JTAP_DCHN_OFS: rd_mux = {23'h0, chan_flag, chan_r};
      JTAP_BRKC_OFS: rd_mux = {30'h0, brkc_r};
      8'h10, 8'h14, 8'h18, 8'h1C: rd_mux = bp_r[paddr[3:2]];
      JTAP_BRKS_OFS: rd_mux = {26'h0, brks_r};
      JTAP_PCDA_OFS: rd_mux = {data_addr, pc_addr};
      default: hit_ofs = 1'b0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_ofs;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // writable registers; apply only when pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= JTAP_CTRL_RST;
      brkc_r <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        bp_r[i] <= '0;
      end
    end else if (wr_en && pready) begin
      unique case (paddr)
        JTAP_CTRL_OFS: ctrl_r <= {27'h0, pwdata[4:0]};
        JTAP_BRKC_OFS: brkc_r <= pwdata[1:0];
        8'h10, 8'h14, 8'h18, 8'h1C: bp_r[paddr[3:2]] <= pwdata;
        default: ;
      endcase
    end
  end

  // channel byte and sticky flag: set wins over debugger clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r <= 8'h00;
      chan_flag <= 1'b0;
    end else if (chan_wr) begin
      chan_r <= chan_wdata;
      chan_flag <= 1'b1;
    end else if (chan_clr && pready) begin
      chan_flag <= 1'b0;
    end
  end

  // sticky break hits and break request, gated by debug enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brks_r <= 6'h00;
      brk_req <= 1'b0;
    end else begin
      brk_req <= dbg_ok & (|hit);
      if (wr_en && pready && paddr == JTAP_BRKS_OFS) begin
        brks_r <= (brks_r & ~pwdata[5:0]) | (dbg_ok ? hit : 6'h00);
      end else begin
        brks_r <= brks_r | (dbg_ok ? hit : 6'h00);
      end
    end
  end

  // ****************************************************
  // misc outputs
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_pullup <= 1'b0;
      dbg_enable <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      pins_pullup <= port_en;
      dbg_enable <= dbg_ok;
      sys_reset_req <= rst_dr_r;                          // reset register, not latched
    end
  end

endmodule : jtap_top
`default_nettype wire

/* File: testbench/jtap_props.sv */
// jtap_props: port checker for jtap_top
// assumes: bound to jtap_top; one pclk domain, presetn async low
`timescale 1ns/1ns
`default_nettype none
module jtap_props
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // test pins
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic pins_pullup,
  // core side
  input wire logic insn_valid,
  input wire logic flow_change,
  input wire logic data_valid,
  input wire logic chan_wr,
  input wire logic chan_flag,
  input wire logic brk_req,
  input wire logic dbg_enable
);
  // core strobe seen in the last two cycles
  logic act_r;
  logic act2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= 1'b0;
      act2_r <= 1'b0;
    end else begin
      act_r <= insn_valid | flow_change | data_valid;
      act2_r <= act_r;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  oe_port_a: assert property (tdo_oe |-> pins_pullup)
    else $error("tdo driven while port off");
  tdo_fall_a: assert property (tdo_oe && $past(tdo_oe) && $changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  brk_debug_a: assert property (brk_req |-> dbg_enable || $past(dbg_enable))
    else $error("break while debug off");
  brk_cause_a: assert property (brk_req |-> act_r || act2_r)
    else $error("break without core event");
  chan_set_a: assert property (chan_wr |=> chan_flag)
    else $error("channel flag not set");
  chan_cause_a: assert property ($rose(chan_flag) |-> $past(chan_wr))
    else $error("channel flag without write");
endmodule // jtap_props
`default_nettype wire

/* File: testbench/jtap_tester.sv */
// jtap_tester: behavioural test-port master on the far side
// assumes: tck period 160 ns, idle low between frames; tdo pulled high
`timescale 1ns/1ns
`default_nettype none
module jtap_tester
(
  // link pins
  output logic tck,
  output logic tms,
  output logic tdi,
  // from the block
  input wire logic tdo,
  input wire logic tdo_oe,
  // shared reset line, open collector, low active
  input wire logic sys_rst_n
);
  logic rst_seen = 1'b0;  // a reset source was seen on the line
  // link clock stands still low outside frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // watch the shared reset line for reset sources
  always @(negedge sys_rst_n) rst_seen = 1'b1;
  // one link period, tdo taken at the rising edge
  task automatic tick(input logic m, input logic d, output logic o);
    #1 tms = m;
    tdi = d;
    #80 tck = 1'b1;
    o = tdo_oe ? tdo : 1'b1; // released line reads high
    #79 tck = 1'b0;
    tdi = 1'b1;
  endtask
  // walk n steps, tms lsb first
  task automatic steps(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(m[i], 1'b1, o);
  endtask
  // shift n bits, leave with tms high, update, back to idle
  task automatic scan(input int n, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
    steps(8'h01, 2);
  endtask
  // instruction scan from idle
  task automatic ir(input logic [3:0] op, output logic [31:0] q);
    steps(8'h03, 4);
    scan(4, {28'h0, op}, q);
  endtask
  // data scan from idle
  task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
    steps(8'h01, 3);
    scan(n, d, q);
  endtask
endmodule // jtap_tester
`default_nettype wire

/* File: testbench/jtap_top_bench.sv */
// jtap_top_bench: scenario bench for jtap_top
// assumes: jtap_tester drives the link; apb and core strobes from here
`timescale 1ns/1ns
`default_nettype none
module jtap_top_bench;
  import jtap_pkg::*;
  // ********
  // signals
  // ********
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, q;
  logic tck, tms, tdi, tdo, tdo_oe, pins_pullup, e, s;
  logic [15:0] pc_addr, data_addr;
  logic insn_valid, flow_change, data_valid, chan_wr;
  logic [7:0] chan_wdata;
  logic chan_flag, brk_req, dbg_enable, sys_reset_req;
  int fail_count = 0;
  int checks = 0;
  always #2 pclk = ~pclk;
  jtap_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pins_pullup(pins_pullup), .pc_addr(pc_addr), .data_addr(data_addr),
    .insn_valid(insn_valid), .flow_change(flow_change), .data_valid(data_valid),
    .chan_wr(chan_wr), .chan_wdata(chan_wdata), .chan_flag(chan_flag),
    .brk_req(brk_req), .dbg_enable(dbg_enable), .sys_reset_req(sys_reset_req));
  jtap_tester i_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .sys_rst_n(~sys_reset_req));
  // ********
  // helpers
  // ********
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      fail_count++;
      finish_test;
    end
  endtask
  // one core strobe, then look for a break request
  task automatic pulse(input int k);
    s = 1'b0;
    @(posedge pclk);
    {insn_valid, flow_change, data_valid} <= {k == 0, k == 1, k == 2};
    @(posedge pclk);
    {insn_valid, flow_change, data_valid} <= 3'b000;
    repeat (4) begin
      @(posedge pclk);
      s = s | (brk_req === 1'b1);
    end
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_tap;
    logic [3:0] ops [5] = '{JTAP_IR_EXTEST, JTAP_IR_SAMPLE, JTAP_IR_RESET, JTAP_IR_BYPASS,
      JTAP_IR_IDCODE};
    apb(0, JTAP_CTRL_OFS, 0);
    chk(r, JTAP_CTRL_RST);
    pc_addr <= 16'h2B1C;
    apb(0, 8'h30, 0);
    chk(e, 1);
    apb(0, JTAP_STAT_OFS, 0);
    chk(r[7:0], {JTAP_IR_IDCODE, 4'h0});
    i_tst.steps(8'h00, 1);
    i_tst.dr(32, 0, q);
    chk(q, JTAP_IDCODE_VAL);
    foreach (ops[i]) begin
      i_tst.ir(ops[i], q);
      chk(q, JTAP_IR_CAPTURE);
      apb(0, JTAP_STAT_OFS, 0);
      chk(r[7:0], {ops[i], 4'h1});
    end
    i_tst.ir(JTAP_IR_EXTEST, q);
    i_tst.dr(16, 32'hBEEF, q);
    chk(q, 32'h2B1C);
    apb(0, JTAP_STAT_OFS, 0);
    chk(r[31:16], 16'hBEEF);
    i_tst.ir(JTAP_IR_BYPASS, q);
    i_tst.dr(8, 32'hA5, q);
    chk(q, 32'h4A);
    i_tst.steps(8'hF9, 8);
    apb(0, JTAP_STAT_OFS, 0);
    chk(r[7:0], {JTAP_IR_IDCODE, 4'h0});
    i_tst.steps(8'h00, 1);
    i_tst.ir(JTAP_IR_RESET, q);
    i_tst.dr(1, 1, q);
    chk(sys_reset_req, 1);
    chk(i_tst.rst_seen, 1);
    i_tst.dr(1, 0, q);
    chk(sys_reset_req, 0);
    $display("tap test done");
  endtask
  task automatic t_port;
    t_off(32'h7);
    t_off(32'h4);
  endtask
  task automatic t_off(input logic [31:0] v);
    apb(1, JTAP_CTRL_OFS, v);
    repeat (4) @(posedge pclk);
    chk(pins_pullup, 0);
    i_tst.dr(8, 0, q);
    chk(q, 32'hFF);
    apb(0, JTAP_STAT_OFS, 0);
    chk(r[8], 0);
    if (v == 32'h4) chk(r[3:0], 0);
    apb(1, JTAP_CTRL_OFS, JTAP_CTRL_RST);
    repeat (4) @(posedge pclk);
    chk(pins_pullup, 1);
    i_tst.steps(8'h00, 1);
    i_tst.dr(32, 0, q);
    chk(q, JTAP_IDCODE_VAL);
    $display("port test done");
  endtask
  task automatic t_debug;
    logic [31:0] locks [3] = '{32'h0E, 32'h16, 32'h02};
    @(posedge pclk);
    pc_addr <= 16'h0123;
    data_addr <= 16'h0040;
    apb(1, JTAP_BP0_OFS, 32'h8000_0123);
    apb(1, JTAP_BP0_OFS + 8'h08, 32'hC000_0040);
    apb(1, JTAP_BP0_OFS + 8'h0C, 32'h8003_0100);
    apb(1, JTAP_BRKC_OFS, 32'h1);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      chk(s, 1);
    end
    apb(0, JTAP_BRKS_OFS, 0);
    chk(r[5:0], 6'h15);
    apb(1, JTAP_BRKS_OFS, 32'h3F);
    apb(0, JTAP_BRKS_OFS, 0);
    chk(r[5:0], 0);
    foreach (locks[i]) begin
      apb(1, JTAP_CTRL_OFS, locks[i]);
      pulse(0);
      chk({dbg_enable, s}, 0);
    end
    apb(1, JTAP_CTRL_OFS, JTAP_CTRL_RST);
    apb(1, JTAP_BRKC_OFS, 32'h2);
    pc_addr <= 16'h0102;
    pulse(0);
    chk({dbg_enable, s}, 3);
    apb(0, JTAP_BRKS_OFS, 0);
    chk(r[5:0], 6'h28);
    @(posedge pclk);
    chan_wdata <= 8'h5A;
    chan_wr <= 1'b1;
    @(posedge pclk);
    chan_wr <= 1'b0;
    apb(0, JTAP_DCHN_OFS, 0);
    chk(r[8:0], 9'h15A);
    apb(0, JTAP_DCHN_OFS, 0);
    chk(r[8:0], 9'h05A);
    $display("debug test done");
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pc_addr, data_addr, insn_valid, flow_change, data_valid} = '0;
    {chan_wr, chan_wdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_tap;
    t_port;
    t_debug;
    finish_test;
  end
  // hang guard
  initial begin
    #300000;
    fail_count++;
    finish_test;
  end
endmodule // jtap_top_bench
bind jtap_top jtap_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .tck(tck), .tdo(tdo),
  .tdo_oe(tdo_oe), .pins_pullup(pins_pullup), .insn_valid(insn_valid),
  .flow_change(flow_change), .data_valid(data_valid), .chan_wr(chan_wr),
  .chan_flag(chan_flag), .brk_req(brk_req), .dbg_enable(dbg_enable));
`default_nettype wire
